//--- verilog/lpc_pkg.sv
// constants and types for the low power clock control block
package lpc_pkg;
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_EXTENDED_INTERRUPT_FLAGS = 8'h91;
	localparam logic [7:0] IDX_PMR = 8'hC4;
	localparam logic [7:0] IDX_STAT = 8'hC5;
	localparam int EXTENDED_INTERRUPT_FLAGS_SRC = 3;
	localparam int EXTENDED_INTERRUPT_FLAGS_RING = 2;
	localparam int PMR_DIV_HI = 7;
	localparam int PMR_DIV_LO = 6;
	localparam int PMR_SWB = 5;
	localparam int PMR_AMP = 3;
	localparam logic [9:0] LAST_4 = 10'h003;
	localparam logic [9:0] LAST_64 = 10'h03F;
	localparam logic [9:0] LAST_1024 = 10'h3FF;
	localparam int WARMUP_XTAL_CLKS = 65536;
	localparam logic RST_SRC = 1'b1;
	localparam logic RST_RING = 1'b0;
	localparam logic RST_SWB = 1'b0;
	localparam logic RST_AMP = 1'b0;
	localparam logic RST_READY = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		DIV_RSVD = 2'b00,
		DIV_4    = 2'b01,
		DIV_64   = 2'b10,
		DIV_1024 = 2'b11
	} lpc_div_t;
	localparam lpc_div_t RST_DIV = DIV_4;
	typedef enum logic [1:0] {
		SEL_NONE = 2'b00,
		SEL_EXTENDED_INTERRUPT_FLAGS = 2'b01,
		SEL_PMR  = 2'b10,
		SEL_STAT = 2'b11
	} lpc_sel_t;
	typedef enum logic [1:0] {
		PEND_IDLE = 2'b00,
		PEND_WAIT = 2'b01,
		PEND_DUE  = 2'b10
	} lpc_pend_t;
endpackage

//--- verilog/lpc_clock_ctrl.sv
// power management clock divider and source control with axi4-lite regs
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module lpc_clock_ctrl #(
	parameter int WARMUP_CLKS = lpc_pkg::WARMUP_XTAL_CLKS
) (
	input  wire logic        aclk,          // core clock
	input  wire logic        aresetn,       // sync reset
	input  wire logic [11:0] awaddr,        // write address
	input  wire logic [2:0]  awprot,        // unused
	input  wire logic        awvalid,       // write addr valid
	output logic             awready,       // write addr ready
	input  wire logic [31:0] wdata,         // write data
	input  wire logic [3:0]  wstrb,         // byte enables
	input  wire logic        wvalid,        // write data valid
	output logic             wready,        // write data ready
	output logic [1:0]       bresp,         // write response
	output logic             bvalid,        // response valid
	input  wire logic        bready,        // response ready
	input  wire logic [11:0] araddr,        // read address
	input  wire logic [2:0]  arprot,        // unused
	input  wire logic        arvalid,       // read addr valid
	output logic             arready,       // read addr ready
	output logic [31:0]      rdata,         // read data
	output logic [1:0]       rresp,         // read response
	output logic             rvalid,        // read valid
	input  wire logic        rready,        // read ready
	input  wire logic        xtal_tick,     // one per crystal clock
	input  wire logic        ring_tick,     // one per ring clock
	input  wire logic [5:0]  ext_irq_req,   // enabled external irqs
	input  wire logic [5:0]  ext_irq_high,  // source is high priority
	input  wire logic        pf_busy,       // powerfail level in service
	input  wire logic        high_busy,     // high level in service
	input  wire logic        low_busy,      // low level in service
	input  wire logic [1:0]  rx_start,      // start bit edge per port
	input  wire logic [1:0]  rx_enable,     // receiver enabled per port
	input  wire logic [1:0]  tx_write,      // tx buffer written per port
	input  wire logic [1:0]  rx_busy,       // word being received
	input  wire logic [1:0]  tx_busy,       // word being shifted out
	output logic             cycle_strobe,  // one per instruction cycle
	output logic [1:0]       div_active,    // divider in use
	output logic             ring_active,   // core runs from ring
	output logic             osc_amp_disable // crystal amplifier off
);

	function automatic lpc_pkg::lpc_sel_t reg_sel(input logic [11:0] a);
		lpc_pkg::lpc_sel_t s;
		s = lpc_pkg::SEL_NONE;
		if (a[11:10] == 2'h0) begin
			case (a[9:2])
				lpc_pkg::IDX_EXTENDED_INTERRUPT_FLAGS: s = lpc_pkg::SEL_EXTENDED_INTERRUPT_FLAGS;
				lpc_pkg::IDX_PMR:  s = lpc_pkg::SEL_PMR;
				lpc_pkg::IDX_STAT: s = lpc_pkg::SEL_STAT;
				default:           s = lpc_pkg::SEL_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic logic [9:0] last_of(input logic [1:0] d);
		logic [9:0] l;
		case (d)
			lpc_pkg::DIV_64: begin
				l = lpc_pkg::LAST_64;
			end
			lpc_pkg::DIV_1024: begin
				l = lpc_pkg::LAST_1024;
			end
			default: begin
				l = lpc_pkg::LAST_4;
			end
		endcase
		return l;
	endfunction

	logic [11:0]         aw_addr;
	logic                aw_held;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                w_held;
	logic                wr_go;
	logic                wr_ok;
	logic                wr_extended_interrupt_flags;
	logic                wr_pmr;
	logic [1:0]          wdiv;
	logic                div_ok;
	logic                src_ok;
	logic                amp_ok;
	logic [1:0]          div_sel;
	logic                src_sel;
	logic                swb_en;
	logic                osc_ready;
	logic [16:0]         warm_cnt;
	lpc_pkg::lpc_pend_t  pend;
	logic [9:0]          cnt;
	logic                tick;
	logic                boundary;
	logic [5:0]          serviceable;
	logic                swb_evt;
	logic [7:0]          rd_byte;
	logic [7:0]          status;

	// bus write path
	assign wr_go = aw_held & w_held & ~bvalid;
	assign wr_ok = wr_go & w_strb[0];
	assign wr_extended_interrupt_flags = wr_ok & (reg_sel(aw_addr) == lpc_pkg::SEL_EXTENDED_INTERRUPT_FLAGS);
	assign wr_pmr = wr_ok & (reg_sel(aw_addr) == lpc_pkg::SEL_PMR);
	assign wdiv = w_data[lpc_pkg::PMR_DIV_HI:lpc_pkg::PMR_DIV_LO];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= lpc_pkg::RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_addr <= awaddr;
				aw_held <= 1'b1;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				w_data <= wdata;
				w_strb <= wstrb;
				w_held <= 1'b1;
				wready <= 1'b0;
			end
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				if (reg_sel(aw_addr) == lpc_pkg::SEL_NONE) begin
					bresp <= lpc_pkg::RESP_SLVERR;
				end else begin
					bresp <= lpc_pkg::RESP_OKAY;
				end
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// register read path
	assign status = {pf_busy, high_busy, low_busy, osc_ready,
		tx_busy[1], rx_busy[1],
		tx_busy[0], rx_busy[0]};

	always_comb begin
		rd_byte = 8'h00;
		case (reg_sel(araddr))
			lpc_pkg::SEL_EXTENDED_INTERRUPT_FLAGS: begin
				rd_byte[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_SRC] = src_sel;
				rd_byte[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_RING] = ring_active;
			end
			lpc_pkg::SEL_PMR: begin
				rd_byte[lpc_pkg::PMR_DIV_HI:lpc_pkg::PMR_DIV_LO] = div_sel;
				rd_byte[lpc_pkg::PMR_SWB] = swb_en;
				rd_byte[lpc_pkg::PMR_AMP] = osc_amp_disable;
			end
			lpc_pkg::SEL_STAT: begin
				rd_byte = status;
			end
			default: begin
				rd_byte = 8'h00;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= lpc_pkg::RESP_OKAY;
		end else begin
			if (arvalid && arready) begin
				arready <= 1'b0;
				rvalid <= 1'b1;
				rdata <= {24'h00_0000, rd_byte};
				if (reg_sel(araddr) == lpc_pkg::SEL_NONE) begin
					rresp <= lpc_pkg::RESP_SLVERR;
				end else begin
					rresp <= lpc_pkg::RESP_OKAY;
				end
			end
			if (rvalid && rready) begin
				rvalid <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// switchback sources
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_irq
			assign serviceable[gi] = ext_irq_req[gi] & ~pf_busy
				& ~high_busy & (ext_irq_high[gi] | ~low_busy);
		end
	endgenerate

	assign swb_evt = swb_en & (|serviceable
		| |(rx_start & rx_enable)
		| |tx_write);

	// write acceptance
	assign div_ok = wr_pmr & (wdiv != div_sel) & (wdiv != lpc_pkg::DIV_RSVD)
		& ((wdiv == lpc_pkg::DIV_4)
		| ((div_active == lpc_pkg::DIV_4)
		& (div_sel == lpc_pkg::DIV_4)));
	assign src_ok = wr_extended_interrupt_flags & (w_data[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_SRC] != src_sel)
		& (~w_data[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_SRC]
		| (osc_ready & ~osc_amp_disable));
	// amp off only once the ring really times the core, else no tick remains
	assign amp_ok = wr_pmr & (~w_data[lpc_pkg::PMR_AMP]
		| (~src_sel & ring_active));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swb_en <= lpc_pkg::RST_SWB;
		end else if (wr_pmr) begin
			swb_en <= w_data[lpc_pkg::PMR_SWB];
		end
	end

	// instruction cycle timing
	assign tick = ring_active ? ring_tick
		: (xtal_tick & ~osc_amp_disable);
	assign boundary = tick & (cnt >= last_of(div_active));

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 10'h000;
			cycle_strobe <= 1'b0;
		end else begin
			cycle_strobe <= boundary;
			if (boundary) begin
				cnt <= 10'h000;
			end else if (tick) begin
				cnt <= cnt + 10'h001;
			end
		end
	end

	// divider and source selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_sel <= lpc_pkg::RST_DIV;
			div_active <= lpc_pkg::RST_DIV;
			src_sel <= lpc_pkg::RST_SRC;
			ring_active <= lpc_pkg::RST_RING;
			pend <= lpc_pkg::PEND_IDLE;
		end else begin
			if (boundary) begin
				case (pend)
					lpc_pkg::PEND_WAIT: begin
						pend <= lpc_pkg::PEND_DUE;
					end
					lpc_pkg::PEND_DUE: begin
						div_active <= div_sel;
						ring_active <= ~src_sel;
						pend <= lpc_pkg::PEND_IDLE;
					end
					default: begin
						pend <= lpc_pkg::PEND_IDLE;
					end
				endcase
			end
			if (div_ok) begin
				div_sel <= wdiv;
				pend <= lpc_pkg::PEND_WAIT;
			end
			if (src_ok) begin
				src_sel <= w_data[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_SRC];
				pend <= lpc_pkg::PEND_WAIT;
			end
			if (swb_evt) begin
				div_sel <= lpc_pkg::DIV_4;
				div_active <= lpc_pkg::DIV_4;
			end
		end
	end

	// crystal amplifier and warm-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_amp_disable <= lpc_pkg::RST_AMP;
		end else if (amp_ok) begin
			osc_amp_disable <= w_data[lpc_pkg::PMR_AMP];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			osc_ready <= lpc_pkg::RST_READY;
			warm_cnt <= 17'h00000;
		end else if (osc_amp_disable) begin
			osc_ready <= 1'b0;
			warm_cnt <= 17'h00000;
		end else if (!osc_ready && xtal_tick) begin
			if (warm_cnt == 17'(WARMUP_CLKS - 1)) begin
				osc_ready <= 1'b1;
			end else begin
				warm_cnt <= warm_cnt + 17'h00001;
			end
		end
	end

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_reset_vals;
		$rose(aresetn) |-> osc_ready && !ring_active && !swb_en
			&& !osc_amp_disable && src_sel && div_active == 2'b01;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");
	property p_div_reject;
		wr_pmr && wdiv[1] && div_active != 2'b01 && !swb_evt
			|=> $stable(div_sel);
	endproperty
	a_div_reject: assert property (p_div_reject)
		else $error("reduced rate taken from reduced rate");
	property p_swb;
		swb_evt |=> div_active == 2'b01 && div_sel == 2'b01
			&& $stable(ring_active);
	endproperty
	a_swb: assert property (p_swb)
		else $error("switchback result wrong");
	property p_no_swb;
		!swb_en && !div_ok && pend != lpc_pkg::PEND_DUE
			|=> $stable(div_sel) && $stable(div_active);
	endproperty
	a_no_swb: assert property (p_no_swb)
		else $error("divider moved without cause");
	property p_lowprio;
		swb_en && high_busy && !(|(ext_irq_req & ext_irq_high))
			&& !(|(rx_start & rx_enable)) && !(|tx_write)
			&& !div_ok && pend != lpc_pkg::PEND_DUE
			|=> $stable(div_active);
	endproperty
	a_lowprio: assert property (p_lowprio)
		else $error("low priority source switched back");
	property p_apply;
		boundary && pend == lpc_pkg::PEND_DUE && !swb_evt
			|=> div_active == $past(div_sel)
			&& ring_active == !$past(src_sel);
	endproperty
	a_apply: assert property (p_apply)
		else $error("pending change not applied");
	property p_wait_cycle;
		div_ok |=> pend == lpc_pkg::PEND_WAIT && $stable(div_active);
	endproperty
	a_wait_cycle: assert property (p_wait_cycle)
		else $error("divider applied too early");
	property p_src_block;
		wr_extended_interrupt_flags && w_data[lpc_pkg::EXTENDED_INTERRUPT_FLAGS_SRC] && !osc_ready
			|=> $stable(src_sel);
	endproperty
	a_src_block: assert property (p_src_block)
		else $error("crystal selected before ready");
	property p_amp_block;
		wr_pmr && w_data[lpc_pkg::PMR_AMP] && src_sel
			|=> $stable(osc_amp_disable);
	endproperty
	a_amp_block: assert property (p_amp_block)
		else $error("amplifier disabled on crystal");
	property p_warm;
		$rose(osc_ready) |-> $past(warm_cnt) == 17'(WARMUP_CLKS - 1);
	endproperty
	a_warm: assert property (p_warm)
		else $error("warm-up length wrong");
	property p_status;
		arvalid && arready && reg_sel(araddr) == lpc_pkg::SEL_STAT
			|=> rvalid && rdata[7:0] == $past(status);
	endproperty
	a_status: assert property (p_status)
		else $error("status read wrong");
	// no cycle shorter than four clocks, switchback included
	property p_strobe4;
		cycle_strobe |=> !cycle_strobe [*3];
	endproperty
	a_strobe4: assert property (p_strobe4)
		else $error("runt instruction cycle");
	c_swb: cover property (swb_evt && div_active == 2'b10);
	c_ring: cover property ($rose(ring_active));
	c_ready: cover property ($rose(osc_ready));
	c_divide_64_mode: cover property ($rose(div_active == 2'b10));

endmodule

//--- verif/tb_lpc_clock_ctrl.sv
// self-checking bench for the low power clock control block
`timescale 1ns/1ps
module tb_lpc_clock_ctrl;
	localparam int WARM = 16;
	localparam logic [11:0] A_EXTENDED_INTERRUPT_FLAGS = {2'b00, lpc_pkg::IDX_EXTENDED_INTERRUPT_FLAGS, 2'b00};
	localparam logic [11:0] A_PMR  = {2'b00, lpc_pkg::IDX_PMR, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, lpc_pkg::IDX_STAT, 2'b00};
	localparam logic [11:0] A_BAD  = 12'h000;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic [2:0]  awprot, arprot;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        xtal_tick, ring_tick, pf_busy, high_busy, low_busy;
	logic [5:0]  ext_irq_req, ext_irq_high, irq;
	logic [1:0]  rx_start, rx_enable, tx_write, rx_busy, tx_busy;
	logic        cycle_strobe, ring_active, osc_amp_disable;
	logic [1:0]  div_active;
	int          failures, n_tests, n;
	integer      seed;

	lpc_clock_ctrl #(.WARMUP_CLKS(WARM)) u_lpc_clock_ctrl (
		.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .xtal_tick, .ring_tick, .ext_irq_req,
		.ext_irq_high, .pf_busy, .high_busy, .low_busy, .rx_start,
		.rx_enable, .tx_write, .rx_busy, .tx_busy, .cycle_strobe,
		.div_active, .ring_active, .osc_amp_disable
	);

	always #50 aclk = ~aclk;

	// crystal ticks only while the amplifier runs
	always @(posedge aclk) begin
		xtal_tick <= (osc_amp_disable !== 1'b1);
		ring_tick <= 1'b1;
	end

	function automatic logic [31:0] st_exp(input logic rdy);
		return {24'h0, pf_busy, high_busy, low_busy, rdy,
			tx_busy[1], rx_busy[1], tx_busy[0], rx_busy[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axw(input logic [11:0] a, input logic [7:0] d,
		input logic [3:0] s);
		bit ad, wd;
		ad = 0;
		wd = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// bounded wait for divider and source outputs
	task automatic wait_st(input logic [2:0] e);
		n = 0;
		while ({div_active, ring_active} !== e && n < 2500) begin
			@(posedge aclk);
			n++;
		end
		chk("div_ring", {29'h0, e}, {29'h0, div_active, ring_active});
	endtask

	task automatic period(input int e);
		do @(posedge aclk); while (cycle_strobe !== 1'b1);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (cycle_strobe !== 1'b1);
		chk("period", e, n);
	endtask

	// software checks the serial ports, then goes via the four clock rate
	task automatic enter(input logic [7:0] v);
		axr(A_STAT);
		chk("serial idle", 32'h0, {28'h0, rd[3:0]});
		axw(A_PMR, {2'b01, v[5:0]}, 4'hF);
		wait_st({2'b01, ring_active});
		axw(A_PMR, v, 4'hF);
		wait_st({v[7:6], ring_active});
	endtask

	task automatic pulse(input logic [1:0] tw, rs, input logic [5:0] q);
		@(posedge aclk);
		tx_write <= tw;
		rx_start <= rs;
		ext_irq_req <= q;
		@(posedge aclk);
		tx_write <= 2'b00;
		rx_start <= 2'b00;
		ext_irq_req <= 6'h00;
		repeat (3) @(posedge aclk);
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge aclk);
		failures++;
		complete_run();
	end

	initial begin
		seed = 32'h4584;
		failures = 0;
		n_tests = 0;
		aclk = 0;
		aresetn = 0;
		{awaddr, araddr, awprot, arprot, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{pf_busy, high_busy, low_busy, ext_irq_req, ext_irq_high} = '0;
		{rx_start, rx_enable, tx_write, rx_busy, tx_busy} = '0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		axr(A_EXTENDED_INTERRUPT_FLAGS);
		chk("extended_interrupt_flags", 32'h08, rd);
		axr(A_PMR);
		chk("pmr", 32'h40, rd);
		repeat (6) begin
			@(posedge aclk);
			{pf_busy, high_busy, low_busy, rx_busy, tx_busy}
				<= 7'($random(seed));
			axr(A_STAT);
			chk("status", st_exp(1'b1), rd);
		end
		{pf_busy, high_busy, low_busy, rx_busy, tx_busy} <= '0;
		axr(A_BAD);
		chk("rresp", lpc_pkg::RESP_SLVERR, resp);
		axw(A_BAD, 8'hFF, 4'hF);
		chk("bresp", lpc_pkg::RESP_SLVERR, resp);
		period(4);
		axw(A_PMR, 8'h00, 4'hF);
		axw(A_PMR, 8'h80, 4'h0);
		repeat (20) @(posedge aclk);
		wait_st(3'b010);
		axw(A_PMR, 8'h80, 4'hF);
		chk("div early", 2'b01, div_active);
		wait_st(3'b100);
		period(64);
		axw(A_PMR, 8'hC0, 4'hF);
		repeat (200) @(posedge aclk);
		wait_st(3'b100);
		axw(A_PMR, 8'h40, 4'hF);
		wait_st(3'b010);
		axw(A_PMR, 8'hC0, 4'hF);
		wait_st(3'b110);
		period(1024);
		axw(A_PMR, 8'h40, 4'hF);
		wait_st(3'b010);
		enter(8'h80);
		pulse(2'b01, 2'b00, 6'h00);
		chk("no return", 2'b10, div_active);
		enter(8'hA0);
		pulse(2'b00, 2'b01, 6'h00);
		chk("rx off", 2'b10, div_active);
		rx_enable <= 2'b11;
		pulse(2'b00, 2'b10, 6'h00);
		chk("rx start", 2'b01, div_active);
		enter(8'hA0);
		irq = 6'h01 << ({$random(seed)} % 6);
		high_busy <= 1'b1;
		pulse(2'b00, 2'b00, irq);
		chk("irq blocked", 2'b10, div_active);
		high_busy <= 1'b0;
		pulse(2'b00, 2'b00, irq);
		chk("irq", 2'b01, div_active);
		enter(8'hA0);
		low_busy <= 1'b1;
		pulse(2'b00, 2'b00, irq);
		chk("irq low", 2'b10, div_active);
		ext_irq_high <= 6'h3F;
		pulse(2'b00, 2'b00, irq);
		chk("irq high", 2'b01, div_active);
		low_busy <= 1'b0;
		enter(8'hA0);
		pulse(2'b10, 2'b00, 6'h00);
		chk("tx write", 2'b01, div_active);
		axw(A_PMR, 8'h48, 4'hF);
		axr(A_PMR);
		chk("amp held", 32'h40, rd);
		axw(A_EXTENDED_INTERRUPT_FLAGS, 8'h00, 4'hF);
		chk("ring early", 1'b0, ring_active);
		wait_st(3'b011);
		axr(A_EXTENDED_INTERRUPT_FLAGS);
		chk("extended_interrupt_flags ring", 32'h04, rd);
		axw(A_PMR, 8'h48, 4'hF);
		chk("amp off", 1'b1, osc_amp_disable);
		axr(A_STAT);
		chk("not ready", 1'b0, rd[4]);
		axw(A_EXTENDED_INTERRUPT_FLAGS, 8'h08, 4'hF);
		axr(A_EXTENDED_INTERRUPT_FLAGS);
		chk("xtal blocked", 32'h04, rd);
		enter(8'hA8);
		pulse(2'b01, 2'b00, 6'h00);
		wait_st(3'b011);
		axw(A_PMR, 8'h40, 4'hF);
		chk("amp on", 1'b0, osc_amp_disable);
		axr(A_STAT);
		chk("warming", 1'b0, rd[4]);
		repeat (WARM + 6) @(posedge aclk);
		axr(A_STAT);
		chk("ready", 1'b1, rd[4]);
		axw(A_EXTENDED_INTERRUPT_FLAGS, 8'h08, 4'hF);
		wait_st(3'b010);
		complete_run();
	end
endmodule
